// [sdo_abort_and_pdo_gate.sv]
// SDO request checker with abort-code generation, and the PDO state gate.
// Assumes requests are decoded CAN frames synchronous to i_clock and that
// the dictionary answers lookups for the request combinationally.
`default_nettype none

module sdo_abort_and_pdo_gate
  import sapg_pkg::*;
(
  input wire logic i_clock,              // System clock, 100 MHz
  input wire logic i_reset,              // Async reset, active high
  input wire logic i_req_valid,          // SDO request strobe
  input wire logic [7:0] i_req_cmd,      // Request byte 0
  input wire logic [15:0] i_req_index,   // Request index
  input wire logic [7:0] i_req_subidx,   // Request subindex
  input wire logic [31:0] i_req_data,    // Request bytes 4..7
  input wire logic i_od_index_exists,    // Dictionary has the index
  input wire logic i_od_sub_exists,      // Dictionary has the subindex
  input wire logic i_od_read_only,       // Entry is constant or read-only
  input wire logic [2:0] i_od_size,      // Entry size in bytes
  input wire logic i_od_has_max,         // Entry has an upper limit
  input wire logic [31:0] i_od_max,      // Upper limit
  input wire logic i_od_has_min,         // Entry has a lower limit
  input wire logic [31:0] i_od_min,      // Lower limit
  input wire logic i_map_target_ok,      // Target of mapping is mappable
  input wire logic i_ul_last,            // Current upload segment is last
  input wire logic [7:0] i_nmt_state,    // Network state code
  input wire logic i_pdo_rx_valid,       // Process data frame received
  input wire logic [3:0] i_pdo_slot,     // Mapping slot to query
  output logic o_rsp_valid,              // Answer strobe
  output logic o_rsp_abort,              // Answer is an abort
  output logic [7:0] o_rsp_cmd,          // Answer byte 0
  output logic [15:0] o_rsp_index,       // Answer index
  output logic [7:0] o_rsp_subidx,       // Answer subindex
  output logic [31:0] o_rsp_code,        // Abort code, zero on success
  output logic o_od_write,               // Entry may be stored
  output logic o_pdo_enable,             // Process data exchange allowed
  output logic o_pdo_rx_take,            // Received frame is accepted
  output logic [3:0] o_pdo_len           // Bytes of selected mapping
);

  // Request decode
  logic [2:0] ccs;                // Client command specifier
  logic is_init_dl;               // Initiate download
  logic is_init_ul;               // Initiate upload
  logic is_seg;                   // Either segment request
  logic is_client_abort;          // Client abort
  logic expedited;                // Expedited with size given
  logic [2:0] exp_bytes;          // Bytes carried when expedited
  logic operational;              // Network is Operational
  logic pdo_param;                // Index is a PDO parameter object
  logic map_entry;                // Write to a mapping content subindex
  logic map_clear;                // Zero written to a mapping count subindex
  logic [3:0] slot;               // Mapping slot of the request
  logic [8:0] map_sum;            // Bit total after the append
  logic err;                      // Request fails
  logic [31:0] code;              // Reason code
  logic commit;                   // Expedited write is stored
  sapg_xfer_t xfer_q;             // Transfer in progress
  sapg_xfer_t xfer_d;             // Next transfer state
  logic toggle_q;                 // Toggle expected in next segment
  logic [6:0] map_bits_q [MAP_SLOTS]; // Mapped bit totals per slot

  assign ccs = i_req_cmd[7:CMD_CCS_LSB];
  assign is_init_dl = ccs == CCS_DL_INIT;
  assign is_init_ul = ccs == CCS_UL_INIT;
  assign is_seg = (ccs == CCS_DL_SEG) || (ccs == CCS_UL_SEG);
  assign is_client_abort = ccs == CCS_ABORT;
  assign expedited = i_req_cmd[CMD_EXPEDITED] && i_req_cmd[CMD_SIZED];
  assign exp_bytes = 3'h4 - {1'b0, i_req_cmd[3:2]};
  assign operational = i_nmt_state == NMT_OPERATIONAL;
  // Low nibble of high index byte selects RX or TX, index[2:0] entry
  assign pdo_param = (i_req_index[15:12] == IDX_COMM_GROUP)
                     && ((i_req_index[11:8] == IDX_RX_COMM)
                      || (i_req_index[11:8] == IDX_RX_MAP)
                      || (i_req_index[11:8] == IDX_TX_COMM)
                      || (i_req_index[11:8] == IDX_TX_MAP))
                     && (i_req_index[7:3] == 5'h00);
  assign slot = {i_req_index[11], i_req_index[2:0]};
  assign map_entry = pdo_param && ((i_req_index[11:8] == IDX_RX_MAP)
                     || (i_req_index[11:8] == IDX_TX_MAP))
                     && (i_req_subidx != 8'h00);
  assign map_clear = pdo_param && ((i_req_index[11:8] == IDX_RX_MAP)
                     || (i_req_index[11:8] == IDX_TX_MAP))
                     && (i_req_subidx == 8'h00) && (i_req_data == '0);
  assign map_sum = {2'b00, map_bits_q[slot]} + {1'b0, i_req_data[7:0]};

  // Checks in fixed precedence; first failing one names the code
  always_comb begin
    err = 1'b1;
    code = '0;
    if (!(is_init_dl || is_init_ul || is_seg)) begin
      code = AB_CMD_UNKNOWN;
    end else if (is_seg) begin
      if ((ccs == CCS_DL_SEG && xfer_q != SAPG_DL)
          || (ccs == CCS_UL_SEG && xfer_q != SAPG_UL)) begin
        code = AB_GENERAL;
      end else if (i_req_cmd[CMD_TOGGLE] != toggle_q) begin
        code = AB_TOGGLE;
      end else begin
        err = 1'b0;
      end
    end else if (i_req_cmd[CMD_FULL_ACCESS]) begin
      code = AB_UNSUPPORTED;
    end else if (!i_od_index_exists) begin
      code = AB_NO_OBJECT;
    end else if (!i_od_sub_exists) begin
      code = AB_NO_SUBINDEX;
    end else if (is_init_dl && i_od_read_only) begin
      code = AB_READ_ONLY;
    end else if (is_init_dl && operational && pdo_param) begin
      code = AB_STATE;
    end else if (is_init_dl && expedited && exp_bytes > i_od_size) begin
      code = AB_LEN_HIGH;
    end else if (is_init_dl && expedited && exp_bytes < i_od_size) begin
      code = AB_LEN_LOW;
    end else if (is_init_dl && expedited && map_entry
                 && !i_map_target_ok) begin
      code = AB_NOT_MAPPABLE;
    end else if (is_init_dl && expedited && map_entry
                 && map_sum > PDO_MAX_BITS) begin
      code = AB_MAP_TOO_LONG;
    end else if (is_init_dl && expedited && i_req_index == IDX_ERR_HISTORY
                 && i_req_subidx == 8'h00 && i_req_data != '0) begin
      code = AB_VALUE_HIGH;
    end else if (is_init_dl && expedited && i_od_has_max
                 && i_req_data > i_od_max) begin
      code = AB_VALUE_HIGH;
    end else if (is_init_dl && expedited && i_od_has_min
                 && i_req_data < i_od_min) begin
      code = AB_VALUE_LOW;
    end else begin
      err = 1'b0;
    end
  end

  // A write is stored only when every check passed
  assign commit = i_req_valid && is_init_dl && expedited && !err;

  // Next transfer state
  always_comb begin
    xfer_d = xfer_q;
    if (i_req_valid) begin
      if (is_client_abort || err) begin
        xfer_d = SAPG_IDLE;
      end else if (is_init_dl) begin
        xfer_d = i_req_cmd[CMD_EXPEDITED] ? SAPG_IDLE : SAPG_DL;
      end else if (is_init_ul) begin
        xfer_d = (i_od_size > 3'h4) ? SAPG_UL : SAPG_IDLE;
      end else if (ccs == CCS_DL_SEG && i_req_cmd[CMD_LAST]) begin
        xfer_d = SAPG_IDLE;
      end else if (ccs == CCS_UL_SEG && i_ul_last) begin
        xfer_d = SAPG_IDLE;
      end
    end
  end

  // Transfer state register
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      xfer_q <= SAPG_IDLE;
    end else begin
      xfer_q <= xfer_d;
    end
  end

  // Toggle restarts at zero on every initiate, even after an abort
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      toggle_q <= 1'b0;
    end else if (i_req_valid && (is_init_dl || is_init_ul)) begin
      toggle_q <= 1'b0;
    end else if (i_req_valid && is_seg && !err) begin
      toggle_q <= ~toggle_q;
    end
  end

  // Answer register; a client abort gets no answer at all
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_rsp_valid <= 1'b0;
      o_rsp_abort <= 1'b0;
      o_rsp_cmd <= '0;
      o_rsp_index <= '0;
      o_rsp_subidx <= '0;
      o_rsp_code <= '0;
      o_od_write <= 1'b0;
    end else begin
      o_rsp_valid <= i_req_valid && !is_client_abort;
      o_od_write <= commit;
      if (i_req_valid && !is_client_abort) begin
        o_rsp_abort <= err;
        o_rsp_index <= i_req_index;
        o_rsp_subidx <= i_req_subidx;
        o_rsp_code <= err ? code : '0;
        if (err) begin
          o_rsp_cmd <= RSP_ABORT;
        end else if (is_init_dl) begin
          o_rsp_cmd <= RSP_DL_INIT;
        end else if (ccs == CCS_DL_SEG) begin
          o_rsp_cmd <= RSP_DL_SEG | {3'b000, toggle_q, 4'h0};
        end else if (is_init_ul) begin
          // Size in command byte only when it fits in one frame
          o_rsp_cmd <= (i_od_size > 3'h4) ? RSP_UL_NORMAL
                       : RSP_UL_EXP | {4'h0, ~i_od_size[1:0] + 2'b01, 2'b00};
        end else begin
          o_rsp_cmd <= {3'b000, toggle_q, 3'b000, i_ul_last};
        end
      end
    end
  end

  // Per-slot mapped bit totals; only committed writes change them
  for (genvar g = 0; g < MAP_SLOTS; g++) begin : g_map
    always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
        map_bits_q[g] <= '0;
      end else if (commit && slot == 4'(g) && map_clear) begin
        map_bits_q[g] <= '0;
      end else if (commit && slot == 4'(g) && map_entry) begin
        map_bits_q[g] <= map_sum[6:0];
      end
    end
  end

  // Process data runs only in Operational; length from stored map
  assign o_pdo_enable = operational;
  assign o_pdo_rx_take = i_pdo_rx_valid && operational;

  // Frame length in bytes, rounded up from the bit total
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_pdo_len <= '0;
    end else begin
      o_pdo_len <= 4'((map_bits_q[i_pdo_slot] + 7'h07) >> 3);
    end
  end

  // Checks
  a_rsp_follows_req: assert property (@(posedge i_clock) disable iff (i_reset)
    i_req_valid && !is_client_abort |=> o_rsp_valid)
    else $error("request not answered");
  a_client_abort_quiet: assert property (@(posedge i_clock)
    disable iff (i_reset)
    i_req_valid && is_client_abort |=> !o_rsp_valid && xfer_q == SAPG_IDLE)
    else $error("client abort answered or transfer kept");
  a_abort_frame_form: assert property (@(posedge i_clock) disable iff (i_reset)
    o_rsp_valid && o_rsp_abort |-> o_rsp_cmd == RSP_ABORT
    && o_rsp_code != '0 && !o_od_write)
    else $error("abort answer malformed");
  a_unknown_cmd_code: assert property (@(posedge i_clock) disable iff (i_reset)
    i_req_valid && ccs > CCS_ABORT |=> o_rsp_code == AB_CMD_UNKNOWN)
    else $error("unknown command code wrong");
  a_read_only_kept: assert property (@(posedge i_clock) disable iff (i_reset)
    i_req_valid && is_init_dl && !i_req_cmd[CMD_FULL_ACCESS]
    && i_od_index_exists && i_od_sub_exists && i_od_read_only
    |=> o_rsp_code == AB_READ_ONLY && !o_od_write)
    else $error("read-only write not refused");
  a_no_sub_code: assert property (@(posedge i_clock) disable iff (i_reset)
    i_req_valid && is_init_ul && !i_req_cmd[CMD_FULL_ACCESS]
    && i_od_index_exists && !i_od_sub_exists
    |=> o_rsp_code == AB_NO_SUBINDEX)
    else $error("missing subindex code wrong");
  a_state_gate_write: assert property (@(posedge i_clock)
    disable iff (i_reset)
    o_od_write && $past(pdo_param) |-> $past(i_nmt_state) != NMT_OPERATIONAL)
    else $error("PDO parameter written in Operational");
  a_toggle_restart: assert property (@(posedge i_clock) disable iff (i_reset)
    i_req_valid && (is_init_dl || is_init_ul) |=> !toggle_q)
    else $error("toggle not reset at initiate");
  a_toggle_repeat: assert property (@(posedge i_clock) disable iff (i_reset)
    i_req_valid && is_seg && xfer_q != SAPG_IDLE
    && i_req_cmd[CMD_TOGGLE] != toggle_q && !(ccs == CCS_DL_SEG
    && xfer_q != SAPG_DL) && !(ccs == CCS_UL_SEG && xfer_q != SAPG_UL)
    |=> o_rsp_code == AB_TOGGLE && xfer_q == SAPG_IDLE)
    else $error("repeated toggle not aborted");
  a_map_limit: assert property (@(posedge i_clock) disable iff (i_reset)
    map_bits_q[i_pdo_slot] <= PDO_MAX_BITS[6:0]
    ##1 o_pdo_len <= 4'(PDO_MAX_BYTES))
    else $error("mapping exceeds eight bytes");
  // Code checks per precedence step look one edge after the request; the store and gate checks look in the same cycle
  a_no_object_code: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_req_valid && (is_init_dl || is_init_ul) && !i_req_cmd[CMD_FULL_ACCESS]
    && !i_od_index_exists |=> o_rsp_code == AB_NO_OBJECT)
    else $error("missing index code wrong");
  a_full_access: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_req_valid && (is_init_dl || is_init_ul) && i_req_cmd[CMD_FULL_ACCESS]
    |=> o_rsp_code == AB_UNSUPPORTED)
    else $error("complete access not refused");
  a_state_code: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_req_valid && is_init_dl && !i_req_cmd[CMD_FULL_ACCESS]
    && i_od_index_exists && i_od_sub_exists && !i_od_read_only
    && operational && pdo_param |=> o_rsp_code == AB_STATE)
    else $error("PDO parameter write code wrong");
  a_seg_no_xfer: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_req_valid && ccs == CCS_DL_SEG && xfer_q != SAPG_DL
    |=> o_rsp_code == AB_GENERAL)
    else $error("stray segment code wrong");
  a_write_clean: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_od_write |-> o_rsp_valid && !o_rsp_abort && o_rsp_code == '0)
    else $error("store strobe on a failed answer");
  a_pdo_gate: assert property (@(posedge i_clock) disable iff (i_reset)
    o_pdo_rx_take |-> i_nmt_state == NMT_OPERATIONAL)
    else $error("process data outside Operational");
  c_expedited_ok: cover property (@(posedge i_clock) disable iff (i_reset)
    o_od_write);
  c_segment_run: cover property (@(posedge i_clock) disable iff (i_reset)
    xfer_q == SAPG_DL ##[1:20] xfer_q == SAPG_IDLE && !o_rsp_abort);
  c_map_overflow: cover property (@(posedge i_clock) disable iff (i_reset)
    o_rsp_valid && o_rsp_code == AB_MAP_TOO_LONG);
  c_state_refused: cover property (@(posedge i_clock) disable iff (i_reset)
    o_rsp_valid && o_rsp_code == AB_STATE);

endmodule : sdo_abort_and_pdo_gate

`default_nettype wire

// [sapg_pkg.sv]
// Constants for the SDO request checker and PDO gate.
// Assumes one 100 MHz system clock; shared by the design and its bench.
`default_nettype none

package sapg_pkg;
  // Client command specifiers, top three bits of the command byte
  localparam logic [2:0] CCS_DL_SEG = 3'h0;
  localparam logic [2:0] CCS_DL_INIT = 3'h1;
  localparam logic [2:0] CCS_UL_INIT = 3'h2;
  localparam logic [2:0] CCS_UL_SEG = 3'h3;
  localparam logic [2:0] CCS_ABORT = 3'h4;
  // Command byte field positions
  localparam int CMD_CCS_LSB = 5;
  localparam int CMD_TOGGLE = 4;
  localparam int CMD_FULL_ACCESS = 4;
  localparam int CMD_EXPEDITED = 1;
  localparam int CMD_SIZED = 0;
  localparam int CMD_LAST = 0;
  // Server answer command bytes
  localparam logic [7:0] RSP_ABORT = 8'h80;
  localparam logic [7:0] RSP_DL_INIT = 8'h60;
  localparam logic [7:0] RSP_DL_SEG = 8'h20;
  localparam logic [7:0] RSP_UL_EXP = 8'h43;
  localparam logic [7:0] RSP_UL_NORMAL = 8'h41;
  // Abort codes
  localparam logic [31:0] AB_TOGGLE = 32'h0503_0000;
  localparam logic [31:0] AB_CMD_UNKNOWN = 32'h0504_0001;
  localparam logic [31:0] AB_UNSUPPORTED = 32'h0601_0000;
  localparam logic [31:0] AB_READ_ONLY = 32'h0601_0002;
  localparam logic [31:0] AB_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] AB_NOT_MAPPABLE = 32'h0604_0041;
  localparam logic [31:0] AB_MAP_TOO_LONG = 32'h0604_0042;
  localparam logic [31:0] AB_LEN_HIGH = 32'h0607_0012;
  localparam logic [31:0] AB_LEN_LOW = 32'h0607_0013;
  localparam logic [31:0] AB_NO_SUBINDEX = 32'h0609_0011;
  localparam logic [31:0] AB_VALUE_HIGH = 32'h0609_0031;
  localparam logic [31:0] AB_VALUE_LOW = 32'h0609_0032;
  localparam logic [31:0] AB_GENERAL = 32'h0800_0000;
  localparam logic [31:0] AB_STATE = 32'h0800_0022;
  // Dictionary indices the checker knows itself
  localparam logic [15:0] IDX_ERR_HISTORY = 16'h1003;
  localparam logic [3:0] IDX_COMM_GROUP = 4'h1;
  localparam logic [3:0] IDX_RX_COMM = 4'h4;
  localparam logic [3:0] IDX_RX_MAP = 4'h6;
  localparam logic [3:0] IDX_TX_COMM = 4'h8;
  localparam logic [3:0] IDX_TX_MAP = 4'hA;
  // Network management states
  localparam logic [7:0] NMT_OPERATIONAL = 8'h05;
  // Process data payload limit
  localparam int PDO_MAX_BYTES = 8;
  localparam logic [8:0] PDO_MAX_BITS = 9'h040;
  localparam int MAP_SLOTS = 16;
  // Transfer states
  typedef enum logic [2:0] {
    SAPG_IDLE = 3'b001,
    SAPG_DL = 3'b010,
    SAPG_UL = 3'b100
  } sapg_xfer_t;
endpackage : sapg_pkg

`default_nettype wire

// [sapg_od_model.sv]
// Dictionary model standing behind the checker's lookup inputs.
// Assumes the bench holds index, subindex and data while a request is up.
`default_nettype none

module sapg_od_model
  import sapg_pkg::*;
(
  input wire logic [15:0] i_index,  // Looked-up index
  input wire logic [7:0] i_subidx,  // Looked-up subindex
  input wire logic [31:0] i_data,   // Request value or mapping entry
  output logic o_exists,            // Index present
  output logic o_sub_exists,        // Subindex present
  output logic o_read_only,         // Constant entry
  output logic [2:0] o_size,        // Size in bytes
  output logic o_has_max,           // Upper limit present
  output logic [31:0] o_max,        // Upper limit
  output logic o_has_min,           // Lower limit present
  output logic [31:0] o_min         // Lower limit
  , output logic o_map_ok           // Named object may be mapped
);
  logic pdo_param; // Index lies in a PDO parameter group

  // Groups 14xx, 16xx, 18xx, 1Axx with entries 0..7 only
  assign pdo_param = (i_index[15:12] == 4'h1) && (i_index[7:3] == 5'h00)
    && (i_index[11:8] inside {4'h4, 4'h6, 4'h8, 4'hA});
  // Only the constant type object is refused in a mapping
  assign o_map_ok = (i_data[31:16] != 16'h1000);
  // Limits are shared; only one entry enables them
  assign o_max = 32'h0000_000A;
  assign o_min = 32'h0000_0001;

  // Lookup, answered in the same cycle as the request
  always_comb begin
    o_exists = 1'b1;
    o_sub_exists = (i_subidx == 8'h00);
    o_read_only = 1'b0;
    o_size = 3'h4;
    o_has_max = 1'b0;
    o_has_min = 1'b0;
    case (i_index)
      16'h1000: o_read_only = 1'b1; // Constant device type
      16'h1003: o_size = 3'h1; // Stored-error count
      16'h1009: begin // Long string, segmented upload
        o_read_only = 1'b1;
        o_size = 3'h5;
      end
      16'h6060: begin // Byte with both limits
        o_size = 3'h1;
        o_has_max = 1'b1;
        o_has_min = 1'b1;
      end
      16'h607A: o_size = 3'h4; // Plain 32-bit entry
      default: begin // PDO groups, else absent
        o_exists = pdo_param;
        o_sub_exists = (i_subidx <= 8'h08);
        if (i_subidx == 8'h00) o_size = 3'h1;
      end
    endcase
  end
endmodule : sapg_od_model

`default_nettype wire

// [tb_sdo_abort_and_pdo_gate.sv]
// Self-checking bench for the SDO checker and PDO gate.
// Assumes the dictionary model answers lookups combinationally.
`default_nettype none

module tb_sdo_abort_and_pdo_gate import sapg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] NMT_PREOP = 8'h7F; // Any non-operational code
  logic i_clock = 1'b0, i_reset = 1'b1, i_req_valid = 1'b0;
  logic [7:0] i_req_cmd = 8'h00, i_req_subidx = 8'h00;
  logic [7:0] i_nmt_state = NMT_PREOP;
  logic [15:0] i_req_index = 16'h0000;
  logic [31:0] i_req_data = 32'h0000_0000;
  logic i_ul_last = 1'b0, i_pdo_rx_valid = 1'b0;
  logic [3:0] i_pdo_slot = 4'h0;
  logic od_ex, od_sub, od_ro, od_hmax, od_hmin, map_ok; // Model answers
  logic [2:0] od_size;
  logic [31:0] od_max, od_min, o_rsp_code;
  logic o_rsp_valid, o_rsp_abort, o_od_write, o_pdo_enable, o_pdo_rx_take;
  logic [7:0] o_rsp_cmd, o_rsp_subidx;
  logic [15:0] o_rsp_index;
  logic [3:0] o_pdo_len;
  int mismatches = 0, n_compared = 0, cycles = 0;

  sapg_od_model i_od (.i_index(i_req_index), .i_subidx(i_req_subidx),
    .i_data(i_req_data), .o_exists(od_ex), .o_sub_exists(od_sub),
    .o_read_only(od_ro), .o_size(od_size), .o_has_max(od_hmax),
    .o_max(od_max), .o_has_min(od_hmin), .o_min(od_min),
    .o_map_ok(map_ok));

  localparam logic [31:0] NONE = 32'h0000_0000; // Success code

  sdo_abort_and_pdo_gate i_dut (
    .i_clock(i_clock), .i_reset(i_reset), .i_req_valid(i_req_valid),
    .i_req_cmd(i_req_cmd), .i_req_index(i_req_index),
    .i_req_subidx(i_req_subidx), .i_req_data(i_req_data),
    .i_od_index_exists(od_ex), .i_od_sub_exists(od_sub),
    .i_od_read_only(od_ro), .i_od_size(od_size), .i_od_has_max(od_hmax),
    .i_od_max(od_max), .i_od_has_min(od_hmin), .i_od_min(od_min),
    .i_map_target_ok(map_ok), .i_ul_last(i_ul_last),
    .i_nmt_state(i_nmt_state), .i_pdo_rx_valid(i_pdo_rx_valid),
    .i_pdo_slot(i_pdo_slot), .o_rsp_valid(o_rsp_valid),
    .o_rsp_abort(o_rsp_abort), .o_rsp_cmd(o_rsp_cmd),
    .o_rsp_index(o_rsp_index), .o_rsp_subidx(o_rsp_subidx),
    .o_rsp_code(o_rsp_code), .o_od_write(o_od_write),
    .o_pdo_enable(o_pdo_enable), .o_pdo_rx_take(o_pdo_rx_take),
    .o_pdo_len(o_pdo_len));

  // Clock, 10 ns period
  always #5 i_clock = ~i_clock;

  // Watchdog: a hang counts as a mismatch and ends the run
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      report_and_stop();
    end
  end

  // One compare; case inequality lets no unknown through
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held over one rising edge, answer judged while it stands
  task automatic sdo(input logic [7:0] cmd, input logic [15:0] idx,
                     input logic [7:0] sub, input logic [31:0] data,
                     input logic [31:0] exp_code);
    @(negedge i_clock);
    i_req_valid = 1'b1;
    i_req_cmd = cmd;
    i_req_index = idx;
    i_req_subidx = sub;
    i_req_data = data;
    @(negedge i_clock);
    i_req_valid = 1'b0;
    chk(o_rsp_valid, cmd[7:5] != CCS_ABORT);
    if (cmd[7:5] != CCS_ABORT) begin
      chk(o_rsp_code, exp_code);
      chk(o_rsp_abort, exp_code != NONE);
      chk(o_rsp_index, idx);
      chk(o_rsp_subidx, sub);
      chk(o_od_write, exp_code == NONE && cmd[7:5] == CCS_DL_INIT
          && cmd[1:0] == 2'b11);
      if (exp_code != NONE) chk(o_rsp_cmd, RSP_ABORT);
    end
  endtask : sdo

  // Slot query; length shows one edge later
  task automatic pdo_len(input logic [3:0] s, input logic [3:0] exp);
    @(negedge i_clock);
    i_pdo_slot = s;
    @(negedge i_clock);
    chk(o_pdo_len, exp);
  endtask : pdo_len

  // Expedited transfers and single-request abort codes other than the state and mapping ones
  task automatic t_expedited();
    sdo(8'h2F, 16'h6060, 8'h00, 32'h0000_0005, NONE);
    chk(o_rsp_cmd, RSP_DL_INIT);
    sdo(8'h2F, 16'h6060, 8'h00, 32'h0000_000B, AB_VALUE_HIGH);
    sdo(8'h2F, 16'h6060, 8'h00, NONE, AB_VALUE_LOW);
    sdo(8'h23, 16'h6060, 8'h00, 32'h0000_0005, AB_LEN_HIGH);
    sdo(8'h2F, 16'h607A, 8'h00, 32'h0000_0005, AB_LEN_LOW);
    sdo(8'h2F, 16'h1003, 8'h00, 32'h0000_0001, AB_VALUE_HIGH);
    sdo(8'h2F, 16'h1003, 8'h00, NONE, NONE);
    sdo(8'h23, 16'h1000, 8'h00, 32'h0000_0001, AB_READ_ONLY);
    sdo(8'h40, 16'h2000, 8'h01, NONE, AB_NO_OBJECT);
    sdo(8'h40, 16'h607A, 8'h01, NONE, AB_NO_SUBINDEX);
    sdo(8'hE0, 16'h2000, 8'h00, NONE, AB_CMD_UNKNOWN);
    sdo(8'h50, 16'h607A, 8'h00, NONE, AB_UNSUPPORTED);
    sdo(8'h00, 16'h607A, 8'h00, NONE, AB_GENERAL);
    sdo(8'h40, 16'h6060, 8'h00, NONE, NONE);
    chk(o_rsp_cmd, 8'h4F);
    $display("t_expedited done");
  endtask : t_expedited

  // Segmented upload and download, toggle and client abort
  task automatic t_segmented();
    sdo(8'h40, 16'h1009, 8'h00, NONE, NONE);
    chk(o_rsp_cmd, RSP_UL_NORMAL);
    sdo(8'h60, 16'h1009, 8'h00, NONE, NONE);
    chk(o_rsp_cmd, 8'h00);
    i_ul_last = 1'b1;
    sdo(8'h70, 16'h1009, 8'h00, NONE, NONE);
    chk(o_rsp_cmd, 8'h11);
    i_ul_last = 1'b0;
    sdo(8'h60, 16'h1009, 8'h00, NONE, AB_GENERAL);
    sdo(8'h21, 16'h607A, 8'h00, NONE, NONE);
    sdo(8'h00, 16'h607A, 8'h00, NONE, NONE);
    chk(o_rsp_cmd, RSP_DL_SEG);
    sdo(8'h00, 16'h607A, 8'h00, NONE, AB_TOGGLE);
    sdo(8'h10, 16'h607A, 8'h00, NONE, AB_GENERAL);
    sdo(8'h21, 16'h607A, 8'h00, NONE, NONE);
    sdo(8'h00, 16'h607A, 8'h00, NONE, NONE);
    sdo(8'h80, 16'h607A, 8'h00, NONE, NONE);
    sdo(8'h10, 16'h607A, 8'h00, NONE, AB_GENERAL);
    sdo(8'h21, 16'h607A, 8'h00, NONE, NONE);
    sdo(8'h00, 16'h607A, 8'h00, NONE, NONE);
    sdo(8'h11, 16'h607A, 8'h00, NONE, NONE);
    chk(o_rsp_cmd, 8'h30);
    $display("t_segmented done");
  endtask : t_segmented

  // Mapping built in Pre-Operational, then cleared by a mid-run reset
  task automatic t_pdo_map();
    sdo(8'h2F, 16'h1600, 8'h00, NONE, NONE);
    sdo(8'h23, 16'h1600, 8'h01, 32'h6040_0010, NONE);
    sdo(8'h23, 16'h1600, 8'h02, 32'h607A_0020, NONE);
    pdo_len(4'h0, 4'h6);
    sdo(8'h23, 16'h1600, 8'h03, 32'h607A_0020, AB_MAP_TOO_LONG);
    sdo(8'h23, 16'h1600, 8'h03, 32'h1000_0020, AB_NOT_MAPPABLE);
    sdo(8'h23, 16'h1600, 8'h03, 32'h6040_0010, NONE);
    pdo_len(4'h0, 4'h8);
    sdo(8'h23, 16'h1A07, 8'h01, 32'h6041_0008, NONE);
    pdo_len(4'hF, 4'h1);
    pdo_len(4'h8, 4'h0);
    @(negedge i_clock);
    i_reset = 1'b1;
    @(negedge i_clock);
    i_reset = 1'b0;
    chk(o_rsp_valid, 1'b0);
    pdo_len(4'h0, 4'h0);
    $display("t_pdo_map done");
  endtask : t_pdo_map

  // Operational: process data flows, parameter writes refused
  task automatic t_operational();
    i_nmt_state = NMT_OPERATIONAL;
    i_pdo_rx_valid = 1'b1;
    @(negedge i_clock);
    chk(o_pdo_enable, 1'b1);
    chk(o_pdo_rx_take, 1'b1);
    sdo(8'h23, 16'h1400, 8'h01, NONE, AB_STATE);
    sdo(8'h2F, 16'h1A07, 8'h00, NONE, AB_STATE);
    sdo(8'h2F, 16'h6060, 8'h00, 32'h0000_0002, NONE);
    sdo(8'h40, 16'h1A07, 8'h00, NONE, NONE);
    i_nmt_state = NMT_PREOP;
    @(negedge i_clock);
    chk(o_pdo_enable, 1'b0);
    chk(o_pdo_rx_take, 1'b0);
    i_pdo_rx_valid = 1'b0;
    $display("t_operational done");
  endtask : t_operational

  // Counts, then the one verdict
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // Reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    i_reset = 1'b0;
    t_expedited();
    t_segmented();
    t_pdo_map();
    t_operational();
    report_and_stop();
  end
endmodule : tb_sdo_abort_and_pdo_gate

`default_nettype wire
